// [design/tablet_position_writer.sv]
`timescale 1ns/10ps
`include "tablet_position_writer_map.svh"
module tablet_position_writer
	import tablet_position_writer_pkg::*;
#(
	parameter int RES = 12,
	parameter int AW = 18,
	parameter int CW = 18,
	parameter int unsigned PACE_CYCLES = `TPW_PACE_CYCLES
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [RES-1:0] pos_x,
	input wire logic [RES-1:0] pos_y,
	input wire logic pos_strobe,
	input wire logic [1:0] pen_z,
	output logic [AW-1:0] mem_addr,
	output logic [35:0] mem_data,
	output logic mem_we,
	input wire logic mem_ack,
	output logic irq
);
	localparam int PW = 2 * RES + 3;
	localparam logic [11:0] LOW_MASK = 12'((1 << (12 - RES)) - 1);

	// Pin synchroniser; stage one is read only by stage two.
	logic [PW-1:0] sync1;
	logic [PW-1:0] sync2;
	logic strobe_d;

	wire logic [PW-1:0] pin_in = {pen_z, pos_strobe, pos_x, pos_y};
	wire logic [RES-1:0] sx = sync2[2*RES-1:RES];
	wire logic [RES-1:0] sy = sync2[RES-1:0];
	wire logic s_strobe = sync2[2*RES];
	wire logic [1:0] s_pen = sync2[PW-1:PW-2];
	wire logic strobe_rise = s_strobe && !strobe_d;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync1 <= '0;
			sync2 <= '0;
			strobe_d <= 1'b0;
		end else begin
			sync1 <= pin_in;
			sync2 <= sync1;
			strobe_d <= s_strobe;
		end
	end

	// Left-align the coordinate in 12 bits, then sign-extend to a half.
	function automatic half_t fmt(input logic [RES-1:0] c);
		logic [11:0] c12;
		c12 = 12'(c) << (12 - RES);
		return {{6{c12[11]}}, c12};
	endfunction : fmt

	wire logic [35:0] pos_word = {fmt(sx), fmt(sy)};

	// AHB-Lite slave: zero wait states, always OKAY.
	logic wr_pend;
	logic [7:0] wr_off;
	wire logic acc = hsel && hready && htrans[1];
	wire logic [7:0] a_off = haddr[7:0];

	wire logic we_ctrl = wr_pend && (wr_off == `TPW_CTRL_OFF);
	wire logic we_addr = wr_pend && (wr_off == `TPW_ADDR_OFF);
	wire logic we_count = wr_pend && (wr_off == `TPW_COUNT_OFF);
	wire logic we_istat = wr_pend && (wr_off == `TPW_ISTAT_OFF);
	wire logic we_imask = wr_pend && (wr_off == `TPW_IMASK_OFF);

	// Block state.
	state_t state;
	state_t next_state;
	logic enable;
	logic [AW-1:0] addr;
	logic [CW-1:0] count;
	logic [35:0] last_word;
	logic fresh;
	logic [1:0] z_flags;
	logic [1:0] irq_stat;
	logic [1:0] irq_mask;

	pace_if pace();

	pacing_timer #(
		.CYCLES(PACE_CYCLES)
	) u_timer (
		.hclk(hclk),
		.hresetn(hresetn),
		.pace(pace)
	);

	wire logic [CW-1:0] count_inc = count + 1'b1;
	wire logic last = !count_inc[CW-1];
	wire logic count_pos = !count[CW-1];

	logic take;
	logic wrote;
	logic start_pace;

	always_comb begin
		next_state = state;
		take = 1'b0;
		wrote = 1'b0;
		start_pace = 1'b0;
		case (state)
			ST_IDLE: begin
				if (enable) begin
					next_state = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (!enable) begin
					next_state = ST_IDLE;
				end else if (fresh) begin
					take = 1'b1;
					next_state = ST_WRITE;
				end
			end
			ST_WRITE: begin
				// A word under way completes even if writing was stopped.
				if (mem_ack) begin
					wrote = 1'b1;
					start_pace = !last;
					next_state = last ? ST_IDLE : ST_PACE;
				end
			end
			ST_PACE: begin
				if (!enable) begin
					next_state = ST_IDLE;
				end else if (pace.expired) begin
					next_state = ST_WAIT;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	assign pace.start = start_pace;

	// A positive count wins over a software set of the flag.
	wire logic next_enable = count_pos ? 1'b0 :
		we_ctrl ? hwdata[`TPW_CTRL_EN] : enable;

	wire logic [AW-1:0] next_addr = wrote ? addr + 1'b1 :
		we_addr ? hwdata[AW-1:0] : addr;
	wire logic [CW-1:0] next_count = wrote ? count_inc :
		we_count ? hwdata[CW-1:0] : count;

	// A new sample sets the flag even in the cycle it is consumed.
	wire logic next_fresh = strobe_rise || (fresh && !take);

	wire logic ev_done = wrote && last;
	wire logic [1:0] ev = {wrote, ev_done};
	wire logic [1:0] w1c = we_istat ? hwdata[1:0] : 2'h0;
	wire logic [1:0] next_istat = (irq_stat & ~w1c) | ev;
	wire logic [1:0] next_imask = we_imask ? hwdata[1:0] : irq_mask;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= ST_IDLE;
			enable <= `TPW_EN_RST;
			addr <= `TPW_ADDR_RST;
			count <= `TPW_COUNT_RST;
		end else begin
			state <= next_state;
			enable <= next_enable;
			addr <= next_addr;
			count <= next_count;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			last_word <= '0;
			fresh <= 1'b0;
			z_flags <= 2'h0;
		end else begin
			if (strobe_rise) begin
				last_word <= pos_word;
			end
			fresh <= next_fresh;
			z_flags <= s_pen;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mem_we <= 1'b0;
			mem_addr <= '0;
			mem_data <= '0;
		end else begin
			if (take) begin
				mem_we <= 1'b1;
				mem_addr <= addr;
				mem_data <= last_word;
			end else if (mem_ack) begin
				mem_we <= 1'b0;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_stat <= `TPW_IRQ_RST;
			irq_mask <= `TPW_IRQ_RST;
			irq <= 1'b0;
		end else begin
			irq_stat <= next_istat;
			irq_mask <= next_imask;
			irq <= |(next_istat & next_imask);
		end
	end

	wire logic busy = (state != ST_IDLE);
	wire logic [3:0] status = {fresh, busy, z_flags};

	wire logic [31:0] rd_word =
		(a_off == `TPW_CTRL_OFF) ? 32'(enable) :
		(a_off == `TPW_STATUS_OFF) ? 32'(status) :
		(a_off == `TPW_ADDR_OFF) ? 32'(addr) :
		(a_off == `TPW_COUNT_OFF) ? 32'(count) :
		(a_off == `TPW_ISTAT_OFF) ? 32'(irq_stat) :
		(a_off == `TPW_IMASK_OFF) ? 32'(irq_mask) :
		(a_off == `TPW_POS_OFF) ? last_word[35:4] : 32'h0000_0000;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_off <= 8'h00;
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			wr_pend <= acc && hwrite;
			wr_off <= a_off;
			hrdata <= (acc && !hwrite) ? rd_word : 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// Checks.
	int unsigned pace_cnt;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pace_cnt <= 0;
		end else begin
			pace_cnt <= (state == ST_PACE) ? pace_cnt + 1 : 0;
		end
	end

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	sequence s_more_write;
		wrote && !last;
	endsequence

	sequence s_held_off;
		(state == ST_PACE && !mem_we) [*3];
	endsequence

	property p_enable_gate;
		(state == ST_WAIT && !enable) |=> (state == ST_IDLE);
	endproperty
	a_enable_gate: assert property (p_enable_gate)
		else $error("Writing continued without the enable flag");

	property p_pen_flags;
		##1 z_flags == $past(s_pen);
	endproperty
	a_pen_flags: assert property (p_pen_flags)
		else $error("Pen flags do not follow the pen inputs");

	property p_addr_used;
		take |=> mem_we && mem_addr == $past(addr);
	endproperty
	a_addr_used: assert property (p_addr_used)
		else $error("Word not written at the write address");

	property p_count_step;
		wrote |=> count == $past(count) + 1'b1;
	endproperty
	a_count_step: assert property (p_count_step)
		else $error("Write count did not step by one");

	property p_halves;
		take |=> mem_data == $past(last_word);
	endproperty
	a_halves: assert property (p_halves)
		else $error("Written word differs from the sampled position");

	property p_signed;
		strobe_rise |=> last_word[35:30] == {6{last_word[29]}}
			&& last_word[17:12] == {6{last_word[11]}};
	endproperty
	a_signed: assert property (p_signed)
		else $error("Coordinate half not sign extended");

	property p_low_zero;
		strobe_rise |=> (last_word[29:18] & LOW_MASK) == 12'h000
			&& (last_word[11:0] & LOW_MASK) == 12'h000;
	endproperty
	a_low_zero: assert property (p_low_zero)
		else $error("Unresolved coordinate bits are not zero");

	property p_pace_len;
		(state == ST_PACE && pace.expired) |->
			pace_cnt == PACE_CYCLES - 1;
	endproperty
	a_pace_len: assert property (p_pace_len)
		else $error("Pacing period has the wrong length");

	property p_pace_hold;
		s_more_write ##1 enable |-> s_held_off;
	endproperty
	a_pace_hold: assert property (p_pace_hold)
		else $error("Next write not held off by the timer");

	property p_single_fast;
		(wrote && last) |=> (state == ST_IDLE) && !pace.expired;
	endproperty
	a_single_fast: assert property (p_single_fast)
		else $error("Final write was paced");

	property p_reset_clear;
		$rose(hresetn) |-> !enable;
	endproperty
	a_reset_clear: assert property (p_reset_clear)
		else $error("Enable flag set after system clear");

	property p_pos_clear;
		count_pos |=> !enable;
	endproperty
	a_pos_clear: assert property (p_pos_clear)
		else $error("Enable flag survived a positive count");

	property p_addr_step;
		wrote |=> addr == $past(addr) + 1'b1;
	endproperty
	a_addr_step: assert property (p_addr_step)
		else $error("Write address did not advance by one");

	property p_irq;
		##1 irq == |($past(next_istat) & $past(next_imask));
	endproperty
	a_irq: assert property (p_irq)
		else $error("Interrupt output disagrees with status and mask");

endmodule : tablet_position_writer

// [common/tablet_position_writer_map.svh]
`ifndef TABLET_POSITION_WRITER_MAP_SVH
`define TABLET_POSITION_WRITER_MAP_SVH

// Register byte offsets, decoded on haddr[7:0].
`define TPW_CTRL_OFF 8'h00
`define TPW_STATUS_OFF 8'h04
`define TPW_ADDR_OFF 8'h08
`define TPW_COUNT_OFF 8'h0c
`define TPW_ISTAT_OFF 8'h10
`define TPW_IMASK_OFF 8'h14
`define TPW_POS_OFF 8'h18

// Field positions.
`define TPW_CTRL_EN 0
`define TPW_STAT_Z5 0
`define TPW_STAT_Z6 1
`define TPW_STAT_BUSY 2
`define TPW_STAT_FRESH 3
`define TPW_IRQ_DONE 0
`define TPW_IRQ_WORD 1

// Reset values.
`define TPW_EN_RST 1'b0
`define TPW_ADDR_RST 18'h00000
`define TPW_COUNT_RST 18'h00000
`define TPW_IRQ_RST 2'h0

// Pacing time and clock rate; the cycle count is derived from both.
`define TPW_PACE_MS 20
`define TPW_CLK_KHZ 25000
`define TPW_PACE_CYCLES (`TPW_PACE_MS * `TPW_CLK_KHZ)

`endif

// [common/tablet_position_writer_pkg.sv]
package tablet_position_writer_pkg;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_WAIT,
		ST_WRITE,
		ST_PACE
	} state_t;

	typedef logic [17:0] half_t;

endpackage : tablet_position_writer_pkg

// [common/pace_if.sv]
`timescale 1ns/10ps
interface pace_if;
	logic start;
	logic expired;

	modport owner (
		output start,
		input expired
	);

	modport timer (
		input start,
		output expired
	);
endinterface : pace_if

// [design/pacing_timer.sv]
`timescale 1ns/10ps
module pacing_timer #(
	parameter int unsigned CYCLES = 500000
) (
	input wire logic hclk,
	input wire logic hresetn,
	pace_if.timer pace
);
	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LOAD = CW'(CYCLES - 1);

	logic [CW-1:0] cnt;
	logic run;
	wire logic at_zero = (cnt == '0);
	wire logic [CW-1:0] next_cnt = pace.start ? LOAD :
		(run && !at_zero) ? cnt - 1'b1 : cnt;

	// Expiry falls on the last cycle of the period so that the waiting
	// side leaves its pacing state exactly CYCLES cycles after the start.
	assign pace.expired = run && at_zero;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt <= '0;
			run <= 1'b0;
		end else begin
			cnt <= next_cnt;
			run <= pace.start || (run && !at_zero);
		end
	end
endmodule : pacing_timer

// [test/tablet_model.sv]
`timescale 1ns/10ps
module tablet_model #(
	parameter int RES = 10
) (
	input wire logic hclk,
	output logic [RES-1:0] pos_x,
	output logic [RES-1:0] pos_y,
	output logic pos_strobe,
	output logic [1:0] pen_z
);
	initial begin
		pos_x = '0;
		pos_y = '0;
		pos_strobe = 1'b0;
		pen_z = 2'b00;
	end

	// Coordinates are held steady around the strobe rise, then driven to their inverse.
	task automatic present(input logic [RES-1:0] x, input logic [RES-1:0] y);
		@(posedge hclk);
		pos_x <= x;
		pos_y <= y;
		repeat (2) @(posedge hclk);
		pos_strobe <= 1'b1;
		repeat (2) @(posedge hclk);
		pos_strobe <= 1'b0;
		pos_x <= ~x;
		pos_y <= ~y;
	endtask : present

	task automatic set_pen(input logic [1:0] z);
		@(posedge hclk);
		pen_z <= z;
	endtask : set_pen
endmodule : tablet_model

// [test/tablet_position_writer_test.sv]
`timescale 1ns/10ps
`include "tablet_position_writer_map.svh"
module tablet_position_writer_test;
	import tablet_position_writer_pkg::*;
	localparam int PACE = 20;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic mem_ack = 1'b0;
	logic we_d = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] rv;
	logic [1:0] htrans = 2'h0;
	logic [31:0] hrdata;
	logic hreadyout, hresp, pos_strobe, mem_we, irq;
	logic [9:0] pos_x, pos_y;
	logic [1:0] pen_z;
	logic [17:0] mem_addr;
	logic [35:0] mem_data;
	logic [17:0] w_addr [8];
	logic [35:0] w_data [8];
	int t_on [8];
	int t_ack [8];
	int cyc = 0;
	int nw = 0;
	int fail_count = 0;
	int cmp_count = 0;

	always #20 hclk = ~hclk;

	tablet_position_writer #(.RES(10), .PACE_CYCLES(PACE)) u_dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .pos_x(pos_x), .pos_y(pos_y),
		.pos_strobe(pos_strobe), .pen_z(pen_z), .mem_addr(mem_addr),
		.mem_data(mem_data), .mem_we(mem_we), .mem_ack(mem_ack), .irq(irq)
	);

	tablet_model #(.RES(10)) u_tab (
		.hclk(hclk), .pos_x(pos_x), .pos_y(pos_y),
		.pos_strobe(pos_strobe), .pen_z(pen_z)
	);

	// Memory answers one cycle after each request and logs every word.
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		we_d <= mem_we;
		mem_ack <= mem_we & ~mem_ack;
		if (mem_we & ~we_d)
			t_on[nw] <= cyc;
		if (mem_we & mem_ack) begin
			w_addr[nw] <= mem_addr;
			w_data[nw] <= mem_data;
			t_ack[nw] <= cyc;
			nw <= nw + 1;
		end
	end

	function automatic logic [35:0] word(input logic [9:0] x, y);
		return {{6{x[9]}}, x, 2'b00, {6{y[9]}}, y, 2'b00};
	endfunction : word

	task automatic chk(input string nm, input logic [35:0] s, e);
		cmp_count++;
		if (s !== e) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	task automatic bus(input logic [7:0] a, input logic w,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h0, a};
		hwrite <= w;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		q = hrdata;
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(a, 1'b1, d, rv);
	endtask : wr

	task automatic rchk(input logic [7:0] a, input string nm,
		input logic [31:0] e);
		bus(a, 1'b0, 32'h0, rv);
		chk(nm, {4'h0, rv}, {4'h0, e});
		chk("resp", {35'h0, hresp}, 36'h0);
	endtask : rchk

	task automatic wait_nw(input int n);
		for (int i = 0; i < 200 && nw < n; i++) @(posedge hclk);
		chk("words", nw, n);
	endtask : wait_nw

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : summarize

	initial begin
		repeat (20000) @(posedge hclk);
		fail_count++;
		summarize();
	end

	initial begin
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		rchk(`TPW_CTRL_OFF, "ctrl", 32'h0);
		rchk(`TPW_ADDR_OFF, "addr", 32'h0);
		rchk(`TPW_COUNT_OFF, "count", 32'h0);
		rchk(8'h1c, "unmapped", 32'h0);
		wr(`TPW_CTRL_OFF, 32'h1);
		rchk(`TPW_CTRL_OFF, "ctrl_refused", 32'h0);
		$display("test reset done");
		u_tab.set_pen(2'b10);
		repeat (4) @(posedge hclk);
		rchk(`TPW_STATUS_OFF, "pen_hi", 32'h2);
		u_tab.set_pen(2'b01);
		repeat (4) @(posedge hclk);
		rchk(`TPW_STATUS_OFF, "pen_lo", 32'h1);
		$display("test pen done");
		wr(`TPW_IMASK_OFF, 32'h3);
		wr(`TPW_ADDR_OFF, 32'h100);
		wr(`TPW_COUNT_OFF, 32'h3ffff);
		wr(`TPW_CTRL_OFF, 32'h1);
		u_tab.present(10'h1ff, 10'h201);
		wait_nw(1);
		repeat (4) @(posedge hclk);
		chk("addr0", w_addr[0], 18'h100);
		chk("data0", w_data[0], 36'h01ff3f804);
		rchk(`TPW_POS_OFF, "pos", 32'h01ff3f80);
		rchk(`TPW_ADDR_OFF, "addr_adv", 32'h101);
		rchk(`TPW_COUNT_OFF, "count_adv", 32'h0);
		rchk(`TPW_CTRL_OFF, "ctrl_done", 32'h0);
		chk("irq_on", irq, 1'b1);
		rchk(`TPW_ISTAT_OFF, "istat", 32'h3);
		wr(`TPW_ISTAT_OFF, 32'h3);
		repeat (2) @(posedge hclk);
		chk("irq_off", irq, 1'b0);
		$display("test single done");
		wr(`TPW_ADDR_OFF, 32'h200);
		wr(`TPW_COUNT_OFF, 32'h3fffd);
		wr(`TPW_CTRL_OFF, 32'h1);
		for (int k = 1; k < 4; k++) begin
			u_tab.present(10'(k * 64), 10'(1023 - k));
			wait_nw(k + 1);
		end
		repeat (4) @(posedge hclk);
		for (int k = 1; k < 4; k++) begin
			chk("addr_m", w_addr[k], 18'(32'h1ff + k));
			chk("data_m", w_data[k], word(10'(k * 64), 10'(1023 - k)));
		end
		for (int k = 1; k < 3; k++)
			chk("paced", t_on[k + 1] - t_ack[k] >= PACE, 1'b1);
		rchk(`TPW_CTRL_OFF, "ctrl_multi", 32'h0);
		$display("test multi done");
		wr(`TPW_ADDR_OFF, 32'h300);
		wr(`TPW_COUNT_OFF, 32'h3fffe);
		wr(`TPW_CTRL_OFF, 32'h1);
		wr(`TPW_CTRL_OFF, 32'h0);
		u_tab.present(10'h155, 10'h0aa);
		repeat (40) @(posedge hclk);
		chk("held_off", nw, 4);
		rchk(`TPW_STATUS_OFF, "fresh", 32'h9);
		wr(`TPW_CTRL_OFF, 32'h1);
		u_tab.present(10'h0aa, 10'h155);
		wait_nw(5);
		repeat (2) @(posedge hclk);
		chk("addr_en", w_addr[4], 18'h300);
		chk("data_en", w_data[4], word(10'h155, 10'h0aa));
		wr(`TPW_CTRL_OFF, 32'h0);
		$display("test enable done");
		summarize();
	end
endmodule : tablet_position_writer_test
